/* File: design/dpc_top.v */
`timescale 1ns/100ps
`include "dpc_consts.vh"

module dpc_top (
	// system clock and reset
	input  wire                    sys_clk,
	input  wire                    reset,
	// three-wire programming bus
	input  wire                    prog_clk,
	input  wire                    prog_data,
	input  wire                    prog_enable_n,
	// hardware control pins
	input  wire                    principal_hw_powerdown,
	input  wire                    auxiliary_hw_powerdown,
	input  wire                    speedup,
	// phase error pulses from the two phase detectors
	input  wire                    principal_phase_err,
	input  wire                    auxiliary_phase_err,
	// lock pin, open drain
	output reg                     lock_pin_out,
	output reg                     lock_pin_oe,
	// divider coefficients
	output reg  [`DPC_PMAIN_W-1:0] principal_main_coeff,
	output reg  [`DPC_PREF_W-1:0]  principal_ref_coeff,
	output reg  [`DPC_AMAIN_W-1:0] auxiliary_main_coeff,
	output reg  [`DPC_AREF_W-1:0]  auxiliary_ref_coeff,
	// decoded control word
	output reg  [1:0]              test_bits,
	output reg                     lock_sel_principal,
	output reg                     lock_sel_auxiliary,
	output reg                     pump_ratio_hi,
	output reg                     pump_ratio_lo,
	output reg                     principal_soft_powerdown,
	output reg                     auxiliary_soft_powerdown,
	// loop enables and divider restart pulses
	output reg                     principal_div_en,
	output reg                     auxiliary_div_en,
	output reg                     principal_div_sync,
	output reg                     auxiliary_div_sync,
	// pump enables and current multiples
	output reg                     principal_normal_pump_out,
	output reg                     principal_speedup_pump_out,
	output reg                     auxiliary_pump_out,
	output reg  [5:0]              principal_normal_mult,
	output reg  [5:0]              principal_speedup_mult,
	output reg  [5:0]              auxiliary_pump_mult
);

	// normal principal pump multiple for a ratio code
	function [5:0] norm_mult;
		input [1:0] code;
		begin
			if (code[1])
				norm_mult = `DPC_NORM_MULT_LO;
			else
				norm_mult = `DPC_NORM_MULT_HI;
		end
	endfunction

	// fast principal pump multiple for a ratio code
	function [5:0] fast_mult;
		input [1:0] code;
		begin
			case (code)
			2'h0: fast_mult = `DPC_FAST_MULT_00;
			2'h1: fast_mult = `DPC_FAST_MULT_01;
			2'h2: fast_mult = `DPC_FAST_MULT_10;
			default: fast_mult = `DPC_FAST_MULT_11;
			endcase
		end
	endfunction

	// reset values of the two-bit fields, split into single-bit outputs
	// by bit-select so no bits are dropped silently
	localparam [1:0] RST_LOCK  = `DPC_RST_LOCK_SEL;
	localparam [1:0] RST_RATIO = `DPC_RST_RATIO;

	// phase error of one loop as the lock pin sees it; a powered-down
	// loop reports nothing, so a stale detector pulse stays hidden
	function gated_err;
		input err;
		input pd;
		begin
			gated_err = err & ~pd;
		end
	endfunction

	// synchronised copies of every pin
	wire [`DPC_SYNC_W-1:0] pins_sync;
	wire                   sclk_s;
	wire                   sdata_s;
	wire                   sen_n_s;
	wire                   hw_pd_p_s;
	wire                   hw_pd_a_s;
	wire                   speedup_s;
	wire                   perr_p_s;
	wire                   perr_a_s;

	dpc_sync u_sync (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in ({auxiliary_phase_err, principal_phase_err, speedup,
		            auxiliary_hw_powerdown, principal_hw_powerdown,
		            prog_enable_n, prog_data, prog_clk}),
		.sync_out (pins_sync)
	);

	assign sclk_s    = pins_sync[0];
	assign sdata_s   = pins_sync[1];
	assign sen_n_s   = pins_sync[2];
	assign hw_pd_p_s = pins_sync[3];
	assign hw_pd_a_s = pins_sync[4];
	assign speedup_s = pins_sync[5];
	assign perr_p_s  = pins_sync[6];
	assign perr_a_s  = pins_sync[7];

	// previous samples for edge detection
	reg                   sclk_prev_reg;
	reg                   sen_n_prev_reg;
	reg [`DPC_WORD_W-1:0] shift_reg;
	reg [`DPC_WORD_W-1:0] shift_next;
	reg [2:0]             settle_reg;

	wire sclk_rise;
	wire en_rise;
	wire edges_valid;

	// the synchroniser clears to 0, yet the idle enable pin is high, so
	// the first samples after reset would look like an enable rise and
	// load a word nobody sent; edges count only once the synchroniser
	// and the edge history both hold real pin samples
	assign edges_valid = settle_reg[2];
	assign sclk_rise   = sclk_s & ~sclk_prev_reg & edges_valid;
	assign en_rise     = sen_n_s & ~sen_n_prev_reg & edges_valid;

	// word fields
	wire [`DPC_DATA_W-1:0] word_data;
	wire [`DPC_ADDR_W-1:0] word_addr;

	assign word_data = shift_reg[`DPC_DATA_MSB:`DPC_DATA_LSB];
	assign word_addr = shift_reg[`DPC_ADDR_MSB:0];

	// shifting: new bit enters at lsb so the first bit ends up at the top
	always @* begin
		shift_next = shift_reg;
		if (sclk_rise && !sen_n_s)
			shift_next = {shift_reg[`DPC_WORD_W-2:0], sdata_s};
	end

	// edge history and the programming register; no clock count check
	always @(posedge sys_clk) begin
		if (reset) begin
			settle_reg     <= 3'h0;
			sclk_prev_reg  <= 1'b0;
			sen_n_prev_reg <= 1'b1;
			shift_reg      <= {`DPC_WORD_W{1'b0}};
		end else begin
			// fills with ones over the three clocks after reset
			settle_reg     <= {settle_reg[1:0], 1'b1};
			sclk_prev_reg  <= sclk_s;
			sen_n_prev_reg <= sen_n_s;
			shift_reg      <= shift_next;
		end
	end

	// load the addressed latch at the inactive edge of enable;
	// clock pulses alone never change a latch
	always @(posedge sys_clk) begin
		if (reset) begin
			test_bits                <= `DPC_RST_TEST;
			lock_sel_principal       <= RST_LOCK[1];
			lock_sel_auxiliary       <= RST_LOCK[0];
			pump_ratio_hi            <= RST_RATIO[1];
			pump_ratio_lo            <= RST_RATIO[0];
			principal_soft_powerdown <= `DPC_RST_SOFT_PD;
			auxiliary_soft_powerdown <= `DPC_RST_SOFT_PD;
			principal_main_coeff     <= `DPC_RST_PMAIN;
			principal_ref_coeff      <= `DPC_RST_PREF;
			auxiliary_main_coeff     <= `DPC_RST_AMAIN;
			auxiliary_ref_coeff      <= `DPC_RST_AREF;
		end else if (en_rise) begin
			case (word_addr)
			`DPC_ADDR_CTRL: begin
				// test bits stored as written; zeros are normal use
				test_bits <= word_data[`DPC_TEST_HI:`DPC_TEST_LO];
				lock_sel_principal       <= word_data[`DPC_LOCK_P_BIT];
				lock_sel_auxiliary       <= word_data[`DPC_LOCK_A_BIT];
				pump_ratio_hi            <= word_data[`DPC_RATIO_HI_BIT];
				pump_ratio_lo            <= word_data[`DPC_RATIO_LO_BIT];
				principal_soft_powerdown <= word_data[`DPC_SOFT_P_BIT];
				auxiliary_soft_powerdown <= word_data[`DPC_SOFT_A_BIT];
			end
			`DPC_ADDR_PMAIN: begin
				principal_main_coeff <= word_data[`DPC_PMAIN_W-1:0];
			end
			`DPC_ADDR_PREF: begin
				principal_ref_coeff <= word_data[`DPC_PREF_W-1:0];
			end
			`DPC_ADDR_AMAIN: begin
				auxiliary_main_coeff <= word_data[`DPC_AMAIN_W-1:0];
			end
			`DPC_ADDR_AREF: begin
				auxiliary_ref_coeff <= word_data[`DPC_AREF_W-1:0];
			end
			default: begin
				// unused address: nothing is touched
			end
			endcase
		end
	end

	// effective power-down of each loop; soft bits come straight from
	// the latch and pins through the synchroniser, so a soft power-down
	// acts two clocks sooner than a pin
	wire pd_p;
	wire pd_a;
	wire [1:0] ratio;

	assign pd_p  = hw_pd_p_s | principal_soft_powerdown;
	assign pd_a  = hw_pd_a_s | auxiliary_soft_powerdown;
	assign ratio = {pump_ratio_hi, pump_ratio_lo};

	// divider and pump enables; restart pulse when a loop wakes up.
	// the pulse comes from the enable history so a soft and a hard
	// release in the same cycle still give only one restart.
	// the pulse lasts one clock; the dividers must clear their counts
	// on it, otherwise the loop restarts with a random phase
	always @(posedge sys_clk) begin
		if (reset) begin
			principal_div_en           <= 1'b0;
			auxiliary_div_en           <= 1'b0;
			principal_div_sync         <= 1'b0;
			auxiliary_div_sync         <= 1'b0;
			principal_normal_pump_out  <= 1'b0;
			principal_speedup_pump_out <= 1'b0;
			auxiliary_pump_out         <= 1'b0;
		end else begin
			principal_div_en           <= ~pd_p;
			principal_normal_pump_out  <= ~pd_p;
			principal_speedup_pump_out <= ~pd_p & speedup_s;
			auxiliary_div_en           <= ~pd_a;
			auxiliary_pump_out         <= ~pd_a;
			principal_div_sync <= ~pd_p & ~principal_div_en;
			auxiliary_div_sync <= ~pd_a & ~auxiliary_div_en;
		end
	end

	// principal pump current multiples follow the ratio code at all times; the auxiliary one stays fixed
	always @(posedge sys_clk) begin
		if (reset) begin
			principal_normal_mult  <= norm_mult(`DPC_RST_RATIO);
			principal_speedup_mult <= fast_mult(`DPC_RST_RATIO);
			auxiliary_pump_mult    <= `DPC_AUX_MULT;
		end else begin
			principal_normal_mult  <= norm_mult(ratio);
			principal_speedup_mult <= fast_mult(ratio);
			auxiliary_pump_mult    <= `DPC_AUX_MULT;
		end
	end

	// lock pin: open drain pulls low for the selected phase error.
	// a powered-down loop reports no error so its stale pulse is hidden
	reg lock_err;

	always @* begin
		case ({lock_sel_principal, lock_sel_auxiliary})
		2'h1: lock_err = gated_err(perr_a_s, pd_a);
		2'h2: lock_err = gated_err(perr_p_s, pd_p);
		2'h3: lock_err = gated_err(perr_a_s, pd_a) |
		                 gated_err(perr_p_s, pd_p);
		default: lock_err = 1'b0;
		endcase
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			lock_pin_out <= 1'b0;
			lock_pin_oe  <= 1'b0;
		end else begin
			lock_pin_out <= 1'b0;
			lock_pin_oe  <= lock_err;
		end
	end

endmodule

/* File: include/dpc_consts.vh */
`ifndef DPC_CONSTS_VH
`define DPC_CONSTS_VH

// serial word layout
`define DPC_WORD_W        21
`define DPC_DATA_W        17
`define DPC_ADDR_W        4
`define DPC_ADDR_MSB      3
`define DPC_DATA_MSB      20
`define DPC_DATA_LSB      4

// latch addresses carried in the trailing four bits
`define DPC_ADDR_CTRL     4'h0
`define DPC_ADDR_PMAIN    4'h1
`define DPC_ADDR_PREF     4'h2
`define DPC_ADDR_AMAIN    4'h3
`define DPC_ADDR_AREF     4'h4

// control word field positions within the 17-bit data field
`define DPC_TEST_HI       16
`define DPC_TEST_LO       15
`define DPC_LOCK_P_BIT    14
`define DPC_LOCK_A_BIT    13
`define DPC_RATIO_HI_BIT  12
`define DPC_RATIO_LO_BIT  11
`define DPC_SOFT_P_BIT    9
`define DPC_SOFT_A_BIT    8

// coefficient widths
`define DPC_PMAIN_W       17
`define DPC_PREF_W        11
`define DPC_AMAIN_W       14
`define DPC_AREF_W        11

// reset values
`define DPC_RST_TEST      2'h0
`define DPC_RST_LOCK_SEL  2'h0
`define DPC_RST_RATIO     2'h0
`define DPC_RST_SOFT_PD   1'h0
`define DPC_RST_PMAIN     17'h00000
`define DPC_RST_PREF      11'h000
`define DPC_RST_AMAIN     14'h0000
`define DPC_RST_AREF      11'h000

// pump current multiples of the bias current
`define DPC_AUX_MULT      6'h04
`define DPC_NORM_MULT_HI  6'h04
`define DPC_NORM_MULT_LO  6'h02
`define DPC_FAST_MULT_00  6'h10
`define DPC_FAST_MULT_01  6'h20
`define DPC_FAST_MULT_10  6'h18
`define DPC_FAST_MULT_11  6'h20

// synchroniser bundle width
`define DPC_SYNC_W        8

`endif

/* File: design/dpc_sync.v */
`timescale 1ns/100ps
`include "dpc_consts.vh"

// two-flop synchroniser for every input from outside sys_clk
module dpc_sync (
	// clock and reset
	input  wire                   sys_clk,
	input  wire                   reset,
	// asynchronous inputs and their synchronised copies
	input  wire [`DPC_SYNC_W-1:0] async_in,
	output reg  [`DPC_SYNC_W-1:0] sync_out
);

	reg [`DPC_SYNC_W-1:0] meta_reg;

	// first stage is read by the second stage only
	always @(posedge sys_clk) begin
		if (reset) begin
			meta_reg <= {`DPC_SYNC_W{1'b0}};
			sync_out <= {`DPC_SYNC_W{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule

/* File: testbench/dpc_top_sva.sv */
`timescale 1ns/100ps

// watches loop power and pump outputs against their causes, and that the lock pin is never driven high
module dpc_chk (
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       speedup,
	input wire logic       principal_hw_powerdown,
	input wire logic       auxiliary_hw_powerdown,
	input wire logic       principal_soft_powerdown,
	input wire logic       auxiliary_soft_powerdown,
	input wire logic       pump_ratio_hi,
	input wire logic       pump_ratio_lo,
	input wire logic       lock_pin_out,
	input wire logic       principal_div_en,
	input wire logic       auxiliary_div_en,
	input wire logic       principal_div_sync,
	input wire logic       auxiliary_div_sync,
	input wire logic       principal_normal_pump_out,
	input wire logic       principal_speedup_pump_out,
	input wire logic       auxiliary_pump_out,
	input wire logic [5:0] principal_normal_mult,
	input wire logic [5:0] principal_speedup_mult,
	input wire logic [5:0] auxiliary_pump_mult
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);

	// fast multiple the ratio pair asks for
	wire [5:0] fast_exp = pump_ratio_lo ? 6'h20 :
		(pump_ratio_hi ? 6'h18 : 6'h10);

	aux_mult_a: assert property (auxiliary_pump_mult == 6'h04)
		else $error("auxiliary multiple wrong");
	norm_mult_a: assert property (principal_normal_mult ==
		($past(pump_ratio_hi) ? 6'h02 : 6'h04))
		else $error("normal multiple wrong");
	fast_mult_a: assert property (
		principal_speedup_mult == $past(fast_exp))
		else $error("fast multiple wrong");
	soft_p_off_a: assert property (principal_soft_powerdown |=>
		!principal_div_en && !principal_normal_pump_out)
		else $error("principal runs while soft off");
	soft_a_off_a: assert property (auxiliary_soft_powerdown |=>
		!auxiliary_div_en && !auxiliary_pump_out)
		else $error("auxiliary runs while soft off");
	pin_a_off_a: assert property (auxiliary_hw_powerdown [*4] |->
		!auxiliary_div_en && !auxiliary_pump_out)
		else $error("auxiliary runs while pin off");
	p_on_a: assert property ((!principal_hw_powerdown &&
		!principal_soft_powerdown) [*4] |-> principal_div_en &&
		principal_normal_pump_out)
		else $error("principal not running");
	fast_gate_a: assert property (principal_speedup_pump_out |->
		principal_div_en)
		else $error("fast pump without loop");
	fast_off_a: assert property (!speedup [*4] |->
		!principal_speedup_pump_out)
		else $error("fast pump without speedup");
	wake_sync_a: assert property (principal_div_sync ==
		$rose(principal_div_en))
		else $error("principal restart pulse wrong");
	aux_wake_sync_a: assert property (auxiliary_div_sync ==
		$rose(auxiliary_div_en))
		else $error("auxiliary restart pulse wrong");
	drain_only_a: assert property (!lock_pin_out)
		else $error("lock pin driven high");
endmodule

bind dpc_top dpc_chk chk (
	.sys_clk                    (sys_clk),
	.reset                      (reset),
	.speedup                    (speedup),
	.principal_hw_powerdown     (principal_hw_powerdown),
	.auxiliary_hw_powerdown     (auxiliary_hw_powerdown),
	.principal_soft_powerdown   (principal_soft_powerdown),
	.auxiliary_soft_powerdown   (auxiliary_soft_powerdown),
	.pump_ratio_hi              (pump_ratio_hi),
	.pump_ratio_lo              (pump_ratio_lo),
	.lock_pin_out               (lock_pin_out),
	.principal_div_en           (principal_div_en),
	.auxiliary_div_en           (auxiliary_div_en),
	.principal_div_sync         (principal_div_sync),
	.auxiliary_div_sync         (auxiliary_div_sync),
	.principal_normal_pump_out  (principal_normal_pump_out),
	.principal_speedup_pump_out (principal_speedup_pump_out),
	.auxiliary_pump_out         (auxiliary_pump_out),
	.principal_normal_mult      (principal_normal_mult),
	.principal_speedup_mult     (principal_speedup_mult),
	.auxiliary_pump_mult        (auxiliary_pump_mult)
);

/* File: testbench/dpc_host.sv */
`timescale 1ns/100ps

// host end of the three-wire bus; clock rests low between frames
module dpc_host (
	output logic prog_clk,
	output logic prog_data,
	output logic prog_enable_n
);
	initial begin
		prog_clk = 0;
		prog_data = 0;
		prog_enable_n = 1;
	end

	// one bit; data settles a half period before the rising clock
	task automatic bit_out(input logic b);
		prog_data = b;
		#62.5 prog_clk = 1;
		#62.5 prog_clk = 0;
	endtask

	// 25 bits msb first, so four leading bits must fall off the top
	task automatic send(input logic [24:0] w);
		// start just off the system clock edge
		#2 prog_enable_n = 0;
		for (int i = 24; i >= 0; i--)
			bit_out(w[i]);
		#62.5 prog_enable_n = 1;
		prog_data = ~prog_data;
		// stray clocks while idle; an empty frame then reloads the word
		#200 bit_out(~w[0]);
		bit_out(w[0]);
		prog_data = ~prog_data;
		#200 prog_enable_n = 0;
		#250 prog_enable_n = 1;
		#400;
	endtask
endmodule

/* File: testbench/test_dpc_top.sv */
`timescale 1ns/100ps

// random words and pin settings, checked against a shadow of the latches
module test_dpc_top;
	logic sys_clk, reset, speedup, principal_phase_err, auxiliary_phase_err;
	logic principal_hw_powerdown, auxiliary_hw_powerdown;
	wire prog_clk, prog_data, prog_enable_n, lock_pin_out, lock_pin_oe;
	wire principal_div_en, auxiliary_div_en;
	wire principal_div_sync, auxiliary_div_sync;
	wire principal_normal_pump_out, principal_speedup_pump_out;
	wire auxiliary_pump_out, lock_sel_principal, lock_sel_auxiliary;
	wire pump_ratio_hi, pump_ratio_lo;
	wire principal_soft_powerdown, auxiliary_soft_powerdown;
	wire [16:0] principal_main_coeff;
	wire [10:0] principal_ref_coeff, auxiliary_ref_coeff;
	wire [13:0] auxiliary_main_coeff;
	wire [1:0]  test_bits;
	wire [5:0]  principal_normal_mult, principal_speedup_mult;
	wire [5:0]  auxiliary_pump_mult;
	logic [16:0] sh [0:4];
	int err_count, tests_run, cyc;

	dpc_top uut (.*);
	dpc_host host (.*);

	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end

	// hang guard; a full run needs about 21600 cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic end_sim();
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [16:0] e, s);
		tests_run++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask

	function automatic logic [5:0] fmul(input logic [1:0] c);
		return c[0] ? 6'h20 : (c[1] ? 6'h18 : 6'h10);
	endfunction

	// every latch and every decoded output against the shadow copy
	task automatic check_all();
		logic [16:0] c;
		logic pon, aon;
		c = sh[0];
		pon = !principal_hw_powerdown && !c[9];
		aon = !auxiliary_hw_powerdown && !c[8];
		chk("pmain", sh[1], principal_main_coeff);
		chk("pref", sh[2][10:0], principal_ref_coeff);
		chk("amain", sh[3][13:0], auxiliary_main_coeff);
		chk("aref", sh[4][10:0], auxiliary_ref_coeff);
		chk("ctrl", c[16:11], {test_bits, lock_sel_principal,
			lock_sel_auxiliary, pump_ratio_hi, pump_ratio_lo});
		chk("soft", c[9:8], {principal_soft_powerdown,
			auxiliary_soft_powerdown});
		chk("mult", {c[12] ? 6'h02 : 6'h04, fmul(c[12:11])},
			{principal_normal_mult, principal_speedup_mult});
		chk("power", {pon, pon, pon && speedup, aon, aon},
			{principal_div_en, principal_normal_pump_out,
			principal_speedup_pump_out, auxiliary_div_en,
			auxiliary_pump_out});
		chk("lock", (c[14] && pon && principal_phase_err) ||
			(c[13] && aon && auxiliary_phase_err), lock_pin_oe);
	endtask

	initial begin
		logic [16:0] d;
		logic [3:0] a;
		{reset, speedup, principal_phase_err, auxiliary_phase_err} = 4'h8;
		{principal_hw_powerdown, auxiliary_hw_powerdown} = 2'h0;
		err_count = 0;
		tests_run = 0;
		cyc = 0;
		for (int i = 0; i < 5; i++)
			sh[i] = 0;
		void'($urandom(59009));
		repeat (10) @(posedge sys_clk);
		reset <= 0;
		repeat (6) @(posedge sys_clk);
		#1;
		check_all();
		// first 16 words walk every lock and ratio code; later ones
		// include addresses with no latch behind them
		for (int i = 0; i < 48; i++) begin
			a = (i < 16) ? 4'h0 : 4'($urandom_range(0, 7));
			d = 17'($urandom);
			if (a == 0)
				d[16:11] = {2'h0, i[3:0]};
			@(posedge sys_clk);
			{principal_hw_powerdown, auxiliary_hw_powerdown, speedup,
				principal_phase_err, auxiliary_phase_err} <= 5'($urandom);
			host.send({4'($urandom), d, a});
			if (a < 5)
				sh[a] = d;
			check_all();
		end
		end_sim();
	end
endmodule
